// ---- src/tap_pkg.sv ----
/*
  constants, state encoding and shared decode for the tap event
  configuration and status block.
  assumes: one system clock, 8-bit register port from the serial engine.
*/
package tap_pkg;

  // register offsets
  localparam logic [7:0] CFG_ADDR      = 8'h21;
  localparam logic [7:0] SRC_ADDR      = 8'h22;
  localparam logic [7:0] LAT_ADDR      = 8'h27;

  // values after reset and unmapped read answer
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [7:0] SRC_RESET     = 8'h00;
  localparam logic [7:0] LAT_RESET     = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // configuration field positions
  localparam int CFG_ABORT_BIT    = 7;
  localparam int CFG_LATCH_BIT    = 6;
  localparam int CFG_Z_DOUBLE_BIT = 5;
  localparam int CFG_Z_SINGLE_BIT = 4;
  localparam int CFG_Y_DOUBLE_BIT = 3;
  localparam int CFG_Y_SINGLE_BIT = 2;
  localparam int CFG_X_DOUBLE_BIT = 1;
  localparam int CFG_X_SINGLE_BIT = 0;

  // source field positions
  localparam int SRC_ACTIVE_BIT   = 7;
  localparam int SRC_AXIS_LSB     = 4;
  localparam int SRC_DOUBLE_BIT   = 3;
  localparam int SRC_POL_LSB      = 0;

  // latency counter width and terminal count
  localparam int         LAT_WIDTH = 8;
  localparam logic [7:0] LAT_LAST  = 8'h01;
  localparam logic [7:0] LAT_ZERO  = 8'h00;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_LATENCY = 3'b010,
    ST_WINDOW  = 3'b100
  } seq_state_type;

  // per-axis enables {z,y,x} for single or double taps
  function automatic logic [2:0] axis_enables(input logic [7:0] cfg,
                                              input logic       dbl);
    logic [2:0] en;
    en = 3'h0;
    if (dbl) begin
      en = {cfg[CFG_Z_DOUBLE_BIT], cfg[CFG_Y_DOUBLE_BIT],
            cfg[CFG_X_DOUBLE_BIT]};
    end else begin
      en = {cfg[CFG_Z_SINGLE_BIT], cfg[CFG_Y_SINGLE_BIT],
            cfg[CFG_X_SINGLE_BIT]};
    end
    return en;
  endfunction : axis_enables

endpackage : tap_pkg

// ---- src/tap_latency_timer.sv ----
/*
  latency interval counter: counts detector time-step ticks down from
  the programmed latency and pulses done when the interval is over.
  assumes: start, step_tick and load_value come from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tap_latency_timer #(
  parameter int LAT_W = tap_pkg::LAT_WIDTH
) (
  input  wire  logic             clk,
  input  wire  logic             rstn,
  input  wire  logic             start,
  input  wire  logic [LAT_W-1:0] load_value,
  input  wire  logic             step_tick,
  output logic                   busy_q,
  output logic                   done_q
);
  import tap_pkg::*;

  logic [LAT_W-1:0] count_q;

  // width check at elaboration
  if (LAT_W != LAT_WIDTH) begin : g_width_check
    $error("tap_latency_timer: LAT_W must match the 8-bit register");
  end

  // countdown, zero latency ends at once
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= LAT_ZERO;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        count_q <= load_value;
        busy_q  <= (load_value != LAT_ZERO);
        done_q  <= (load_value == LAT_ZERO);
      end else if (busy_q && step_tick) begin
        count_q <= count_q - LAT_LAST;
        if (count_q == LAT_LAST) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

endmodule : tap_latency_timer

`default_nettype wire

// ---- src/tap_source_hold.sv ----
/*
  tap source register: takes qualified events, freezes under latching,
  clears on a read, a new event in the read cycle wins.
  assumes: event and clear strobes are one-cycle pulses on clk.
*/
`timescale 1ns/1ps
`default_nettype none

module tap_source_hold (
  input  wire  logic       clk,
  input  wire  logic       rstn,
  input  wire  logic       evt_valid,
  input  wire  logic       evt_double,
  input  wire  logic [2:0] evt_axes,
  input  wire  logic [2:0] evt_pol,
  input  wire  logic       latch_en,
  input  wire  logic       clear,
  output logic [7:0]       src_q
);
  import tap_pkg::*;

  logic       frozen;
  logic [7:0] src_new;

  assign frozen  = latch_en && src_q[SRC_ACTIVE_BIT];
  assign src_new = {1'b1, evt_axes, evt_double, evt_pol & evt_axes};

  // load, hold or clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      src_q <= SRC_RESET;
    end else if (evt_valid && (clear || !frozen)) begin
      src_q <= src_new;
    end else if (clear) begin
      src_q <= SRC_RESET;
    end
  end

endmodule : tap_source_hold

`default_nettype wire

// ---- src/tap_event_config_status.sv ----
/*
  tap event configuration and status: configuration, latency and
  source registers, single/double tap sequencing with abort option.
  assumes: detector supplies same-clock per-axis pulse start/end strobes,
  polarity, a time-step tick and a window timeout; the serial engine
  gives one-cycle register read and write strobes.
*/
`timescale 1ns/1ps
`default_nettype none

module tap_event_config_status (
  input  wire  logic       clk,
  input  wire  logic       rstn,
  input  wire  logic [7:0] reg_addr,
  input  wire  logic       reg_wr,
  input  wire  logic       reg_rd,
  input  wire  logic [7:0] reg_wdata,
  output logic [7:0]       reg_rdata_q,
  output logic             reg_rvalid_q,
  input  wire  logic [2:0] pulse_start,
  input  wire  logic [2:0] pulse_done,
  input  wire  logic [2:0] pulse_neg,
  input  wire  logic       step_tick,
  input  wire  logic       window_expired,
  output logic [2:0]       single_detect_en,
  output logic [2:0]       double_detect_en,
  output logic             tap_int
);
  import tap_pkg::*;

  logic [7:0]    cfg_q;
  logic [7:0]    lat_q;
  logic [7:0]    src_value;
  seq_state_type state_q;
  seq_state_type state_d;
  logic          start_seen_q;
  logic          abort_q;
  logic          lat_start;
  logic          lat_busy;
  logic          lat_done;
  logic          src_clear;
  logic          evt_valid;
  logic          evt_double;
  logic [2:0]    evt_axes;
  logic [2:0]    evt_pol;
  logic          any_done;
  logic          any_start;
  logic          abort_now;

  assign any_done  = |pulse_done;
  assign any_start = |pulse_start;
  assign src_clear = reg_rd && (reg_addr == SRC_ADDR);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= CFG_RESET;
      lat_q <= LAT_RESET;
    end else if (reg_wr) begin
      if (reg_addr == CFG_ADDR) begin
        cfg_q <= reg_wdata;
      end
      if (reg_addr == LAT_ADDR) begin
        lat_q <= reg_wdata;
      end
    end
  end

  // read data, unmapped reads answer zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q  <= UNMAPPED_DATA;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          CFG_ADDR: reg_rdata_q <= cfg_q;
          SRC_ADDR: reg_rdata_q <= src_value;
          LAT_ADDR: reg_rdata_q <= lat_q;
          default:  reg_rdata_q <= UNMAPPED_DATA;
        endcase
      end
    end
  end

  assign single_detect_en = axis_enables(cfg_q, 1'b0);
  assign double_detect_en = axis_enables(cfg_q, 1'b1);

  // abort when a tap starts and ends inside latency
  assign abort_now = cfg_q[CFG_ABORT_BIT] && state_q == ST_LATENCY &&
                     (start_seen_q || any_start) && any_done;

  // tap sequencer next state
  always_comb begin
    state_d   = state_q;
    lat_start = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (any_done) begin
          state_d   = ST_LATENCY;
          lat_start = 1'b1;
        end
      end
      ST_LATENCY: begin
        // no abort means go on to the window
        if (lat_done) begin
          state_d = (abort_q || abort_now) ? ST_IDLE : ST_WINDOW;
        end
      end
      ST_WINDOW: begin
        if (any_done || window_expired) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // sequencer state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // abort tracking during latency
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_seen_q <= 1'b0;
      abort_q      <= 1'b0;
    end else if (state_q != ST_LATENCY || lat_done) begin
      start_seen_q <= 1'b0;
      abort_q      <= 1'b0;
    end else begin
      if (any_start) begin
        start_seen_q <= 1'b1;
      end
      if (abort_now) begin
        abort_q <= 1'b1;
      end
    end
  end

  // events only outside latency; masked by enables
  always_comb begin
    evt_double = (state_q == ST_WINDOW);
    evt_axes   = 3'h0;
    evt_pol    = pulse_neg;
    if (state_q == ST_IDLE || state_q == ST_WINDOW) begin
      evt_axes = pulse_done & axis_enables(cfg_q, evt_double);
    end
    evt_valid = (evt_axes != 3'h0);
  end

  tap_latency_timer #(
    .LAT_W      (LAT_WIDTH)
  ) u_latency (
    .clk        (clk),
    .rstn       (rstn),
    .start      (lat_start),
    .load_value (lat_q),
    .step_tick  (step_tick),
    .busy_q     (lat_busy),
    .done_q     (lat_done)
  );

  tap_source_hold u_source (
    .clk        (clk),
    .rstn       (rstn),
    .evt_valid  (evt_valid),
    .evt_double (evt_double),
    .evt_axes   (evt_axes),
    .evt_pol    (evt_pol),
    .latch_en   (cfg_q[CFG_LATCH_BIT]),
    .clear      (src_clear),
    .src_q      (src_value)
  );

  assign tap_int = src_value[SRC_ACTIVE_BIT];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_cfg_write;
    reg_wr && reg_addr == CFG_ADDR;
  endsequence

  sequence s_read_alone;
    src_clear && !evt_valid;
  endsequence

  sequence s_free_event;
    evt_valid && !(cfg_q[CFG_LATCH_BIT] && src_value[SRC_ACTIVE_BIT]);
  endsequence

  property p_cfg_write;
    s_cfg_write |=> cfg_q == $past(reg_wdata);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config write not stored");

  property p_disabled;
    state_q == ST_IDLE && (pulse_done & single_detect_en) == 3'h0
      |-> !evt_valid;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled single tap raised an event");

  property p_no_abort;
    state_q == ST_LATENCY && !cfg_q[CFG_ABORT_BIT] && lat_done
      |=> state_q == ST_WINDOW;
  endproperty
  a_no_abort: assert property (p_no_abort)
    else $error("double detection stopped without abort");

  property p_abort;
    abort_q && lat_done |=> state_q == ST_IDLE ##1 !evt_double;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort did not suspend double detection");

  property p_latch_hold;
    cfg_q[CFG_LATCH_BIT] && src_value[SRC_ACTIVE_BIT] && !src_clear
      |=> src_value == $past(src_value);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched source changed before read");

  property p_mask;
    evt_valid |-> (evt_axes & ~axis_enables(cfg_q, evt_double)) == 3'h0;
  endproperty
  a_mask: assert property (p_mask)
    else $error("event on a disabled axis or type");

  property p_active;
    evt_valid |=> src_value[SRC_ACTIVE_BIT] && tap_int;
  endproperty
  a_active: assert property (p_active)
    else $error("active flag not set by event");

  property p_fields;
    s_free_event |=> src_value[6:4] == $past(evt_axes) &&
      src_value[SRC_DOUBLE_BIT] == $past(evt_double) &&
      src_value[2:0] == ($past(evt_pol) & $past(evt_axes));
  endproperty
  a_fields: assert property (p_fields)
    else $error("source fields do not match event");

  property p_clear;
    s_read_alone |=> src_value == SRC_RESET && !tap_int;
  endproperty
  a_clear: assert property (p_clear)
    else $error("read did not clear source");

  property p_ignore;
    state_q == ST_LATENCY |-> !evt_valid;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("tap reported inside latency");

  property p_follow;
    !cfg_q[CFG_LATCH_BIT] && evt_valid
      |=> src_value[6:4] == $past(evt_axes);
  endproperty
  a_follow: assert property (p_follow)
    else $error("unlatched source did not follow event");

  // latency state always has a loaded or finishing timer
  property p_lat_run;
    state_q == ST_LATENCY |-> lat_busy || lat_done;
  endproperty
  a_lat_run: assert property (p_lat_run)
    else $error("latency state without a running timer");

  // a source read answers with the value it clears
  property p_src_read;
    src_clear |=> reg_rvalid_q && reg_rdata_q == $past(src_value);
  endproperty
  a_src_read: assert property (p_src_read)
    else $error("source read returned wrong value");

endmodule : tap_event_config_status

`default_nettype wire

// ---- verification/tap_detector_model.sv ----
/*
  detector stand-in: drives tap start/end strobes, polarity and the
  window timeout on command, and a free-running time-step tick.
  assumes: shares the block's clock; tasks are called from the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module tap_detector_model (
  input  wire logic       clk,
  output logic [2:0]      pulse_start,
  output logic [2:0]      pulse_done,
  output logic [2:0]      pulse_neg,
  output logic            step_tick,
  output logic            window_expired
);
  // quiet lines at time zero
  initial begin
    pulse_start    = 3'h0;
    pulse_done     = 3'h0;
    pulse_neg      = 3'h0;
    step_tick      = 1'b0;
    window_expired = 1'b0;
  end

  // time-step tick every second cycle
  always @(posedge clk) begin
    step_tick <= ~step_tick;
  end

  // one tap: threshold start, then end with polarity
  task automatic tap(input logic [2:0] ax, input logic [2:0] neg);
    @(posedge clk);
    pulse_start <= ax;
    @(posedge clk);
    pulse_start <= 3'h0;
    pulse_done  <= ax;
    pulse_neg   <= neg;
    @(posedge clk);
    pulse_done <= 3'h0;
    pulse_neg  <= ~neg;  // stale polarity not held
  endtask : tap

  // double-tap window runs out
  task automatic expire();
    @(posedge clk);
    window_expired <= 1'b1;
    @(posedge clk);
    window_expired <= 1'b0;
  endtask : expire
endmodule : tap_detector_model

`default_nettype wire

// ---- verification/tap_event_config_status_test.sv ----
/*
  self-checking bench: register accesses over the strobe port and tap
  sequences from the detector stand-in.
  assumes: design files compiled first, one 10 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tap_event_config_status_test;
  import tap_pkg::*;

  logic       clk;
  logic       rstn;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_q;
  logic       reg_rvalid_q;
  logic [2:0] pulse_start;
  logic [2:0] pulse_done;
  logic [2:0] pulse_neg;
  logic       step_tick;
  logic       window_expired;
  logic [2:0] single_detect_en;
  logic [2:0] double_detect_en;
  logic       tap_int;
  int         err_count;
  int         n_compared;

  tap_event_config_status u_dut (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .pulse_start(pulse_start),
    .pulse_done(pulse_done), .pulse_neg(pulse_neg),
    .step_tick(step_tick), .window_expired(window_expired),
    .single_detect_en(single_detect_en),
    .double_detect_en(double_detect_en), .tap_int(tap_int)
  );

  tap_detector_model u_det (
    .clk(clk), .pulse_start(pulse_start), .pulse_done(pulse_done),
    .pulse_neg(pulse_neg), .step_tick(step_tick),
    .window_expired(window_expired)
  );

  // 100 ns clock
  initial clk = 1'b0;
  always #50 clk = ~clk;

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read with bounded wait on the valid pulse, then compare
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    int n;
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    n = 0;
    while (reg_rvalid_q !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 4) begin
      $display("Error at %0t: no read valid", $time);
      err_count++;
      print_verdict();
    end else begin
      chk(reg_rdata_q, exp);
    end
  endtask : rc

  // let latency run out, close the window, clear the source
  task automatic settle();
    repeat (40) @(posedge clk);
    u_det.expire();
    rc(SRC_ADDR, 8'h00);
    rc(SRC_ADDR, 8'h00);
  endtask : settle

  initial begin
    rstn      = 1'b0;
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
    err_count = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;

    // reset values and map
    rc(CFG_ADDR, 8'h00);
    rc(SRC_ADDR, 8'h00);
    rc(LAT_ADDR, 8'h00);
    rc(8'h30, 8'h00);
    chk({7'h00, tap_int}, 8'h00);
    wr(CFG_ADDR, 8'h35);
    rc(CFG_ADDR, 8'h35);
    chk({2'b00, double_detect_en, single_detect_en}, 8'h27);
    wr(SRC_ADDR, 8'hFF);
    rc(SRC_ADDR, 8'h00);
    $display("test registers done");

    // disabled events leave no flag
    wr(CFG_ADDR, 8'h00);
    wr(LAT_ADDR, 8'h02);
    u_det.tap(3'b111, 3'b000);
    rc(SRC_ADDR, 8'h00);
    settle();
    $display("test disabled done");

    // single x only: z masked, negative x polarity
    wr(CFG_ADDR, 8'h01);
    u_det.tap(3'b101, 3'b101);
    // look after the event edge has settled
    #1;
    chk({7'h00, tap_int}, 8'h01);
    rc(SRC_ADDR, 8'h91);
    rc(SRC_ADDR, 8'h00);
    chk({7'h00, tap_int}, 8'h00);
    settle();
    $display("test single done");

    // double tap, latch off: source follows newest event
    wr(CFG_ADDR, 8'h03);
    u_det.tap(3'b001, 3'b000);
    repeat (12) @(posedge clk);
    u_det.tap(3'b001, 3'b001);
    rc(SRC_ADDR, 8'h99);
    settle();
    $display("test double done");

    // latch on: first event frozen until read
    wr(CFG_ADDR, 8'h43);
    u_det.tap(3'b001, 3'b000);
    repeat (12) @(posedge clk);
    u_det.tap(3'b001, 3'b001);
    rc(SRC_ADDR, 8'h90);
    rc(SRC_ADDR, 8'h00);
    settle();
    $display("test latch done");

    // abort clear: tap in latency ignored, later tap is double
    wr(LAT_ADDR, 8'h08);
    wr(CFG_ADDR, 8'h03);
    u_det.tap(3'b001, 3'b000);
    rc(SRC_ADDR, 8'h90);
    u_det.tap(3'b001, 3'b000);
    rc(SRC_ADDR, 8'h00);
    repeat (25) @(posedge clk);
    u_det.tap(3'b001, 3'b000);
    rc(SRC_ADDR, 8'h98);
    settle();
    $display("test no abort done");

    // abort set: tap inside latency suspends the double
    wr(CFG_ADDR, 8'h83);
    u_det.tap(3'b001, 3'b000);
    rc(SRC_ADDR, 8'h90);
    u_det.tap(3'b001, 3'b000);
    repeat (25) @(posedge clk);
    u_det.tap(3'b001, 3'b000);
    rc(SRC_ADDR, 8'h90);
    settle();
    $display("test abort done");

    print_verdict();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    $display("Error at %0t: run limit reached", $time);
    err_count++;
    print_verdict();
  end
endmodule : tap_event_config_status_test

`default_nettype wire
